// file: design/dprb_bank.sv
// Debug port register bank shared by the jtag and serial-wire engines
`default_nettype none
module dprb_bank
  import dprb_pkg::*;
#(
  parameter logic SERIAL_WIRE = 1'b1
)(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        abort_wr,
  input  wire logic [31:0] abort_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        ap_start,
  input  wire logic [1:0]  access_port_request,
  input  wire logic        ap_done,
  input  wire logic        ap_err,
  input  wire logic        ap_rd,
  input  wire logic [31:0] ap_rdata,
  input  wire logic        link_wr_fault,
  input  wire logic        link_overflow,
  input  wire logic        link_clk,
  input  wire logic        system_power_grant,
  input  wire logic        debug_power_grant,
  input  wire logic        debug_domain_reset_grant,
  input  wire logic        external_event_input,
  input  wire logic [31:0] target_id_tie,
  input  wire logic [3:0]  multidrop_instance_number,
  output logic             system_power_request,
  output logic             debug_power_request,
  output logic             debug_domain_reset_request,
  output logic             cancel_transaction,
  output logic      [31:0] apb_addr,
  output logic      [1:0]  bus_handover_length,
  output logic             link_clk_rise
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [2:0] grant_s1_q, grant_s2_q;
  logic       event_s1_q, event_flag_n_q;
  logic       lclk_s1_q, lclk_s2_q, lclk_s3_q;

  // Grants and event pass two flops before the read mux sees them
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      grant_s1_q <= 3'h0;
      grant_s2_q <= 3'h0;
      event_s1_q <= DPRB_RST_EVENT;
      event_flag_n_q <= DPRB_RST_EVENT;
    end
    else
    begin
      grant_s1_q <= {system_power_grant, debug_power_grant, debug_domain_reset_grant};
      grant_s2_q <= grant_s1_q;
      event_s1_q <= ~external_event_input;
      event_flag_n_q <= event_s1_q;
    end
  end

  // Link clock: two sync flops, the third only serves the edge finder
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
    end
    else
    begin
      lclk_s1_q <= link_clk;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [3:0]  port_bank_choice_q;
  logic [27:0] sel_addr_q;

  // Bank match, shared by the write and read decodes
  function automatic logic bank_is(input logic [3:0] sel, input logic [3:0] bank);
    return sel == bank;
  endfunction

  wire         at_ctrl   = reg_addr == DPRB_OFF_CTRL;
  wire         wr_cs     = reg_wr && at_ctrl && bank_is(port_bank_choice_q, DPRB_BANK_CTRL);
  wire         wr_link   = reg_wr && at_ctrl && bank_is(port_bank_choice_q, DPRB_BANK_LINK)
                           && SERIAL_WIRE;
  wire         wr_sel    = reg_wr && reg_addr == DPRB_OFF_SELECT;
  wire         jtag_w1c  = wr_cs && !SERIAL_WIRE;
  wire         ab_f      = abort_wr && abort_wdata[DPRB_AB_FCLR];
  wire         ab_o      = abort_wr && abort_wdata[DPRB_AB_OCLR];
  wire         ab_w      = abort_wr && abort_wdata[DPRB_AB_WCLR];
  wire         rd_buf    = reg_rd && reg_addr == DPRB_OFF_RDBUF && SERIAL_WIRE;

  // ----------------------------------------
  // Control and sticky state
  // ----------------------------------------
  logic sys_req_q, dbg_req_q, rst_req_q, errsel_q, ovwatch_q;
  logic fault_q, ovfl_q, wfault_q, rdgood_q, cancel_q;
  logic [1:0]  handover_q;
  logic [31:0] last_read_q, addr_q;

  wire fault_set = ap_done && ap_err && !errsel_q;
  wire fault_clr = ab_f || (jtag_w1c && reg_wdata[DPRB_CS_FAULT]);
  wire ovfl_set  = ovwatch_q && link_overflow;
  wire ovfl_clr  = ab_o || (jtag_w1c && reg_wdata[DPRB_CS_OVFL]);
  wire wf_set    = SERIAL_WIRE && link_wr_fault;

  // Control bits written through the control/status bank
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sys_req_q <= 1'b0;
      dbg_req_q <= 1'b0;
      rst_req_q <= 1'b0;
      errsel_q  <= 1'b0;
      ovwatch_q <= 1'b0;
    end
    else if (wr_cs)
    begin
      sys_req_q <= reg_wdata[DPRB_CS_SYS_REQ];
      dbg_req_q <= reg_wdata[DPRB_CS_DBG_REQ];
      rst_req_q <= reg_wdata[DPRB_CS_RST_REQ];
      errsel_q  <= reg_wdata[DPRB_CS_ERRSEL];
      ovwatch_q <= reg_wdata[DPRB_CS_OVWATCH];
    end
  end

  // Sticky flags, where a set in the same cycle as a clear wins, and the one-cycle cancel pulse
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fault_q  <= 1'b0;
      ovfl_q   <= 1'b0;
      wfault_q <= 1'b0;
      cancel_q <= 1'b0;
    end
    else
    begin
      fault_q  <= fault_set | (fault_q & ~fault_clr);
      ovfl_q   <= ovfl_set | (ovfl_q & ~ovfl_clr);
      wfault_q <= wf_set | (wfault_q & ~ab_w);
      cancel_q <= abort_wr && abort_wdata[DPRB_AB_CANCEL];
    end
  end

  // Link control and select fields
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      handover_q <= DPRB_RST_HANDOVER;
      port_bank_choice_q <= 4'h0;
      sel_addr_q <= 28'h0;
    end
    else
    begin
      if (wr_link)
        handover_q <= reg_wdata[DPRB_LC_HAND_LO +: 2];
      if (wr_sel)
      begin
        port_bank_choice_q <= reg_wdata[3:0];
        sel_addr_q <= reg_wdata[31:4];
      end
    end
  end

  // Access port address, taken at transfer start and held
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      addr_q <= DPRB_RST_ZERO;
    else if (ap_start)
      addr_q <= {sel_addr_q, access_port_request, 2'b00};
  end

  // Last read result and whether its response was good
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      last_read_q <= DPRB_RST_ZERO;
      rdgood_q    <= 1'b0;
    end
    else if (ap_done && ap_rd)
    begin
      last_read_q <= ap_rdata;
      rdgood_q    <= SERIAL_WIRE && !ap_err;
    end
    else if (rd_buf)
      rdgood_q <= SERIAL_WIRE;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [31:0] cs_word, bank_word, rd_d;
  assign cs_word = {grant_s2_q[2], sys_req_q, grant_s2_q[1], dbg_req_q,
                    grant_s2_q[0], rst_req_q, 1'b0, errsel_q, 16'h0000,
                    wfault_q, rdgood_q, fault_q, 3'b000, ovfl_q, ovwatch_q};
  always_comb
  begin
    unique case (port_bank_choice_q)
      DPRB_BANK_CTRL:  bank_word = cs_word;
      DPRB_BANK_LINK:  bank_word = SERIAL_WIRE ?
                         {22'h0, handover_q, 1'b0, 1'b1, 6'h00} : 32'h0;
      DPRB_BANK_TGTID: bank_word = {target_id_tie[31:1], 1'b1};
      DPRB_BANK_PROT:  bank_word = {(SERIAL_WIRE ? multidrop_instance_number : 4'h0),
                                    24'h0, DPRB_PROT_VERSION};
      DPRB_BANK_EVENT: bank_word = {31'h0, event_flag_n_q};
      default:         bank_word = 32'h0;
    endcase
  end
  always_comb
  begin
    rd_d = 32'h0;
    if (reg_rd)
    begin
      if (at_ctrl)
        rd_d = bank_word;
      else if (reg_addr == DPRB_OFF_RESEND || reg_addr == DPRB_OFF_RDBUF)
        rd_d = SERIAL_WIRE ? last_read_q : 32'h0;
      else if (reg_addr == DPRB_OFF_ID0 && bank_is(port_bank_choice_q, DPRB_BANK_BASE1))
        rd_d = 32'h0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic [31:0] rdata_q;
  logic        rise_q;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= DPRB_RST_ZERO;
      rise_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rd_d;
      rise_q <= lclk_s2_q && !lclk_s3_q;
    end
  end
  assign reg_rdata = rdata_q;
  assign system_power_request = sys_req_q;
  assign debug_power_request = dbg_req_q;
  assign debug_domain_reset_request = rst_req_q;
  assign cancel_transaction = cancel_q;
  assign apb_addr = addr_q;
  assign bus_handover_length = handover_q;
  assign link_clk_rise = rise_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_fault_sets: assert property (@(posedge mclk) disable iff (rst)
    fault_set |=> fault_q) else $error("fault not latched");
  chk_errsel_blocks: assert property (@(posedge mclk) disable iff (rst)
    (errsel_q && !fault_q && !(ap_done && ap_err && !errsel_q)) |=> !fault_q)
    else $error("fault recorded in masked mode");
  chk_fault_clear: assert property (@(posedge mclk) disable iff (rst)
    (ab_f && !fault_set) |=> !fault_q) else $error("fault not cleared");
  chk_serial_nowc: assert property (@(posedge mclk) disable iff (rst)
    (SERIAL_WIRE && fault_q && !abort_wr) |=> fault_q) else $error("fault lost");
  chk_ovfl_watch: assert property (@(posedge mclk) disable iff (rst)
    (!ovwatch_q && !ovfl_q) |=> !ovfl_q) else $error("overflow without watch");
  chk_ovfl_clear: assert property (@(posedge mclk) disable iff (rst)
    (ab_o && !ovfl_set) |=> !ovfl_q) else $error("overflow not cleared");
  chk_sysreq_wr: assert property (@(posedge mclk) disable iff (rst)
    wr_cs |=> system_power_request == $past(reg_wdata[DPRB_CS_SYS_REQ]))
    else $error("power request mismatch");
  chk_addr_held: assert property (@(posedge mclk) disable iff (rst)
    !ap_start |=> $stable(apb_addr)) else $error("address moved");
  chk_addr_low: assert property (@(posedge mclk) disable iff (rst)
    apb_addr[1:0] == 2'b00) else $error("address low bits");
  chk_event_path: assert property (@(posedge mclk) disable iff (rst)
    ##2 (event_flag_n_q == !$past(external_event_input, 2)))
    else $error("event flag wrong");
  chk_handover: assert property (@(posedge mclk) disable iff (rst)
    wr_link |=> bus_handover_length == $past(reg_wdata[9:8]))
    else $error("handover mismatch");
  chk_dbgreq_wr: assert property (@(posedge mclk) disable iff (rst)
    wr_cs |=> debug_power_request == $past(reg_wdata[DPRB_CS_DBG_REQ]))
    else $error("debug power request mismatch");
  chk_rstreq_wr: assert property (@(posedge mclk) disable iff (rst)
    wr_cs |=> debug_domain_reset_request == $past(reg_wdata[DPRB_CS_RST_REQ]))
    else $error("debug reset request mismatch");
  chk_wfault_sets: assert property (@(posedge mclk) disable iff (rst)
    wf_set |=> wfault_q) else $error("write fault not latched");
  chk_wfault_clear: assert property (@(posedge mclk) disable iff (rst)
    (ab_w && !wf_set) |=> !wfault_q) else $error("write fault not cleared");
  chk_ovfl_sets: assert property (@(posedge mclk) disable iff (rst)
    ovfl_set |=> ovfl_q) else $error("overflow not latched");
  chk_cancel_pulse: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> cancel_transaction == $past(abort_wr && abort_wdata[DPRB_AB_CANCEL]))
    else $error("cancel pulse wrong");
  chk_sel1_ignored: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && at_ctrl && port_bank_choice_q == DPRB_BANK_SEL1)
    |=> $stable({sys_req_q, dbg_req_q, rst_req_q, errsel_q, ovwatch_q, handover_q}))
    else $error("upper select write took effect");

  // ----------------------------------------
  // Read, address and handover checks
  // ----------------------------------------
  chk_rdgood_read: assert property (@(posedge mclk) disable iff (rst)
    (ap_done && ap_rd) |=> rdgood_q == (SERIAL_WIRE && !$past(ap_err)))
    else $error("read good flag wrong");
  chk_last_read: assert property (@(posedge mclk) disable iff (rst)
    (ap_done && ap_rd) |=> last_read_q == $past(ap_rdata))
    else $error("last read not kept");
  chk_handover_hold: assert property (@(posedge mclk) disable iff (rst)
    !wr_link |=> $stable(bus_handover_length)) else $error("handover moved");
  chk_link_one: assert property (@(posedge mclk) disable iff (rst)
    (reg_rd && at_ctrl && port_bank_choice_q == DPRB_BANK_LINK)
    |=> reg_rdata[DPRB_LC_ONE] == SERIAL_WIRE) else $error("link bit6 wrong");
  chk_tgt_bit0: assert property (@(posedge mclk) disable iff (rst)
    (reg_rd && at_ctrl && port_bank_choice_q == DPRB_BANK_TGTID)
    |=> reg_rdata[0]) else $error("identity bit0 low");
  chk_prot_version: assert property (@(posedge mclk) disable iff (rst)
    (reg_rd && at_ctrl && port_bank_choice_q == DPRB_BANK_PROT)
    |=> reg_rdata[3:0] == DPRB_PROT_VERSION) else $error("protocol version wrong");
  chk_base_high: assert property (@(posedge mclk) disable iff (rst)
    (reg_rd && reg_addr == DPRB_OFF_ID0 && port_bank_choice_q == DPRB_BANK_BASE1)
    |=> reg_rdata == 32'h0000_0000) else $error("upper base word not zero");
  chk_addr_load: assert property (@(posedge mclk) disable iff (rst)
    ap_start |=> apb_addr == {$past(sel_addr_q), $past(access_port_request), 2'b00})
    else $error("address not taken");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cov_fault: cover property (@(posedge mclk) disable iff (rst) fault_set ##1 ab_f);
  cov_link_rise: cover property (@(posedge mclk) disable iff (rst) link_clk_rise);
  cov_ovfl_clear: cover property (@(posedge mclk) disable iff (rst) ovfl_q ##1 ab_o);
  cov_read: cover property (@(posedge mclk) disable iff (rst) ap_done && ap_rd ##[1:4] rd_buf);
  cov_power: cover property (@(posedge mclk) disable iff (rst) wr_cs ##[1:8] grant_s2_q[2]);
endmodule : dprb_bank
`default_nettype wire

// file: design/dprb_pkg.sv
// Constants for the debug port register bank
`default_nettype none
package dprb_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] DPRB_OFF_ID0    = 8'h00;
  localparam logic [7:0] DPRB_OFF_CTRL   = 8'h04;
  localparam logic [7:0] DPRB_OFF_RESEND = 8'h08;
  localparam logic [7:0] DPRB_OFF_RDBUF  = 8'h0C;
  localparam logic [7:0] DPRB_OFF_SELECT = 8'h80;
  // ----------------------------------------
  // Bank choices at offset 0x04 and 0x00
  // ----------------------------------------
  localparam logic [3:0] DPRB_BANK_CTRL  = 4'h0;
  localparam logic [3:0] DPRB_BANK_LINK  = 4'h1;
  localparam logic [3:0] DPRB_BANK_TGTID = 4'h2;
  localparam logic [3:0] DPRB_BANK_PROT  = 4'h3;
  localparam logic [3:0] DPRB_BANK_EVENT = 4'h4;
  localparam logic [3:0] DPRB_BANK_SEL1  = 4'h5;
  localparam logic [3:0] DPRB_BANK_BASE1 = 4'h3;
  // ----------------------------------------
  // Control/status field positions
  // ----------------------------------------
  localparam int DPRB_CS_SYS_GNT = 31;
  localparam int DPRB_CS_SYS_REQ = 30;
  localparam int DPRB_CS_DBG_GNT = 29;
  localparam int DPRB_CS_DBG_REQ = 28;
  localparam int DPRB_CS_RST_GNT = 27;
  localparam int DPRB_CS_RST_REQ = 26;
  localparam int DPRB_CS_ERRSEL  = 24;
  localparam int DPRB_CS_WFAULT  = 7;
  localparam int DPRB_CS_RDGOOD  = 6;
  localparam int DPRB_CS_FAULT   = 5;
  localparam int DPRB_CS_OVFL    = 1;
  localparam int DPRB_CS_OVWATCH = 0;
  // ----------------------------------------
  // Abort bits, link control, reset values
  // ----------------------------------------
  localparam int DPRB_AB_CANCEL  = 0;
  localparam int DPRB_AB_FCLR    = 2;
  localparam int DPRB_AB_WCLR    = 3;
  localparam int DPRB_AB_OCLR    = 4;
  localparam int DPRB_LC_HAND_LO = 8;
  localparam int DPRB_LC_ONE     = 6;
  localparam logic [3:0]  DPRB_PROT_VERSION = 4'h1;
  localparam logic [31:0] DPRB_RST_ZERO     = 32'h0000_0000;
  localparam logic [1:0]  DPRB_RST_HANDOVER = 2'h0;
  localparam logic        DPRB_RST_EVENT    = 1'b1;
endpackage : dprb_pkg
`default_nettype wire

// file: tb/dprb_bank_test.sv
// Self-checking bench for the debug port register bank
`default_nettype none
module dprb_bank_test
  import dprb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Tie-off identity values are arbitrary
  localparam logic [31:0] TIE_ID   = 32'h5A5A_A5A4;
  localparam logic [3:0]  TIE_INST = 4'hB;
  logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, abort_wr = 1'b0;
  logic        ap_start = 1'b0, ap_done = 1'b0, ap_err = 1'b0, ap_rd = 1'b0, link_on = 1'b0;
  logic        wr_fault = 1'b0, ovfl = 1'b0, link_clk = 1'b0, evt_in = 1'b0, cancel, rise;
  logic [1:0]  ap_req = 2'h0, handover;
  logic [2:0]  req, gnt;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] wdata = 32'h0, abort_data = 32'h0, ap_data = 32'h0, rdata, apb_addr;
  int          n_errors = 0, comparisons = 0, n_rise = 0;
  always #20 mclk = ~mclk;
  always #160 if (link_on) link_clk = ~link_clk;
  always @(posedge mclk) if (rise === 1'b1) n_rise++;
  dprb_bank #(.SERIAL_WIRE(1'b1)) uut (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(wdata), .abort_wr(abort_wr), .abort_wdata(abort_data), .reg_rdata(rdata),
    .ap_start(ap_start), .access_port_request(ap_req), .ap_done(ap_done), .ap_err(ap_err),
    .ap_rd(ap_rd), .ap_rdata(ap_data), .link_wr_fault(wr_fault), .link_overflow(ovfl),
    .link_clk(link_clk), .system_power_grant(gnt[2]), .debug_power_grant(gnt[1]),
    .debug_domain_reset_grant(gnt[0]), .external_event_input(evt_in),
    .target_id_tie(TIE_ID), .multidrop_instance_number(TIE_INST),
    .system_power_request(req[2]), .debug_power_request(req[1]),
    .debug_domain_reset_request(req[0]), .cancel_transaction(cancel),
    .apb_addr(apb_addr), .bus_handover_length(handover), .link_clk_rise(rise)
  );
  dprb_power_model #(.LAG(3)) pwr (.mclk(mclk), .rst(rst), .req(req), .gnt(gnt));
  // ----------------------------------------
  // Bus tasks, entered and left just after an edge
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk(rdata, want);
    tick(1);
  endtask
  task automatic ab(input logic [31:0] d);
    abort_data = d;
    abort_wr = 1'b1;
    tick(1);
    abort_wr = 1'b0;
    chk({31'h0, cancel}, {31'h0, d[0]});
    tick(1);
  endtask
  task automatic ap(input logic [1:0] q, input logic r, input logic e, input logic [31:0] d);
    ap_req = q;
    ap_rd = r;
    ap_err = e;
    ap_data = d;
    ap_start = 1'b1;
    tick(1);
    ap_start = 1'b0;
    ap_done = 1'b1;
    tick(1);
    ap_done = 1'b0;
    ap_data = ~d;
    tick(1);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_banks;
    logic [31:0] tab [5];
    tab = '{32'h0, 32'h40, {TIE_ID[31:1], 1'b1}, {TIE_INST, 24'h0, 4'h1}, 32'h1};
    for (int b = 0; b < 5; b++)
    begin
      wr(DPRB_OFF_SELECT, 32'(b));
      rdc(DPRB_OFF_CTRL, tab[b]);
    end
    evt_in = 1'b1;
    tick(4);
    rdc(DPRB_OFF_CTRL, 32'h0);
    wr(DPRB_OFF_SELECT, {28'h0, DPRB_BANK_SEL1});
    wr(DPRB_OFF_CTRL, 32'hFFFF_FFFF);
    wr(DPRB_OFF_SELECT, {28'h0, DPRB_BANK_BASE1});
    rdc(DPRB_OFF_ID0, 32'h0);
    wr(DPRB_OFF_RDBUF, {TIE_INST, TIE_ID[27:1], 1'b1});
    rdc(DPRB_OFF_RESEND, 32'h0);
    wr(DPRB_OFF_SELECT, 32'h0);
    rdc(DPRB_OFF_CTRL, 32'h0);
  endtask
  task automatic t_power;
    wr(DPRB_OFF_CTRL, 32'h5400_0000);
    chk({29'h0, req}, 32'h7);
    tick(8);
    rdc(DPRB_OFF_CTRL, 32'hFC00_0000);
    wr(DPRB_OFF_CTRL, 32'h1400_0000);
    tick(8);
    rdc(DPRB_OFF_CTRL, 32'h3C00_0000);
    wr(DPRB_OFF_CTRL, 32'h0);
    tick(8);
  endtask
  task automatic t_faults;
    ap(2'h1, 1'b0, 1'b1, 32'h0);
    rdc(DPRB_OFF_CTRL, 32'h20);
    wr(DPRB_OFF_CTRL, 32'h20);
    rdc(DPRB_OFF_CTRL, 32'h20);
    ab(32'h4);
    wr(DPRB_OFF_CTRL, 32'h0100_0001);
    ap(2'h1, 1'b0, 1'b1, 32'h0);
    ovfl = 1'b1;
    tick(1);
    ovfl = 1'b0;
    wr_fault = 1'b1;
    tick(1);
    wr_fault = 1'b0;
    rdc(DPRB_OFF_CTRL, 32'h0100_0083);
    wr(DPRB_OFF_CTRL, 32'h0100_0083);
    rdc(DPRB_OFF_CTRL, 32'h0100_0083);
    ab(32'h1D);
    rdc(DPRB_OFF_CTRL, 32'h0100_0001);
    wr(DPRB_OFF_CTRL, 32'h0);
  endtask
  task automatic t_reads;
    wr(DPRB_OFF_SELECT, 32'hABCD_E120);
    ap(2'h2, 1'b1, 1'b0, 32'h1234_5678);
    chk(apb_addr, 32'hABCD_E128);
    wr(DPRB_OFF_SELECT, 32'h1111_1110);
    chk(apb_addr, 32'hABCD_E128);
    rdc(DPRB_OFF_CTRL, 32'h40);
    rdc(DPRB_OFF_RESEND, 32'h1234_5678);
    rdc(DPRB_OFF_RDBUF, 32'h1234_5678);
    rdc(DPRB_OFF_RDBUF, 32'h1234_5678);
    ap(2'h3, 1'b1, 1'b1, 32'h0BAD_0BAD);
    chk(apb_addr, 32'h1111_111C);
    rdc(DPRB_OFF_CTRL, 32'h20);
    ab(32'h4);
  endtask
  task automatic t_link;
    wr(DPRB_OFF_SELECT, {28'h0, DPRB_BANK_LINK});
    for (int c = 0; c < 4; c++)
    begin
      wr(DPRB_OFF_CTRL, {22'h0, 2'(c), 8'h0});
      chk({30'h0, handover}, 32'(c));
      rdc(DPRB_OFF_CTRL, {22'h0, 2'(c), 8'h40});
    end
    n_rise = 0;
    link_on = 1'b1;
    repeat (10) @(link_clk);
    link_on = 1'b0;
    tick(8);
    chk(32'(n_rise), 32'd5);
  endtask
  initial
  begin
    tick(16);
    rst = 1'b0;
    tick(1);
    chk({27'h0, req, handover}, 32'h0);
    t_banks();
    evt_in = 1'b0;
    t_power();
    t_faults();
    t_reads();
    t_link();
    summarize();
  end
  // Cuts a hang short well past the expected run length
  initial
  begin
    #(40 * 4000);
    n_errors++;
    summarize();
  end
endmodule // dprb_bank_test
`default_nettype wire

// file: tb/dprb_power_model.sv
// Power and reset controller that grants each request level after a lag
`default_nettype none
module dprb_power_model #(
  parameter int LAG = 3
)(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [2:0] req,
  output logic      [2:0] gnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3*LAG-1:0] dly_q;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      dly_q <= '0;
    else
      dly_q <= {dly_q[3*LAG-4:0], req};
  assign gnt = dly_q[3*LAG-1 -: 3];
endmodule // dprb_power_model
`default_nettype wire
